// File: hdl/astx_consts.vh
/*
 * Constants for the asynchronous serial transmitter: register
 * offsets, field positions, reset values and timing counts.
 * Assumes inclusion by bare name from the design file only.
 */
`ifndef ASTX_CONSTS_VH
`define ASTX_CONSTS_VH

// Register bus widths
`define ASTX_ADDR_W        3
`define ASTX_DATA_W        8

// Register offsets (word index on the plain port)
`define ASTX_OFS_STATCTL   3'h0
`define ASTX_OFS_TXBUF     3'h1
`define ASTX_OFS_BAUD      3'h2
`define ASTX_OFS_FLAGS     3'h3
`define ASTX_OFS_ENABLES   3'h4
`define ASTX_OFS_PORTCTL   3'h5

// Transmit status and control fields
`define ASTX_SC_CLKSRC     7
`define ASTX_SC_NINE       6
`define ASTX_SC_TRANSMIT_ENABLE       5
`define ASTX_SC_CLKMODE    4
`define ASTX_SC_SHEMPTY    1
`define ASTX_SC_NINTH      0

// Peripheral flag and enable fields
`define ASTX_FL_BUFEMPTY   1
`define ASTX_EN_BUFEMPTY   1

// Port control field
`define ASTX_PC_PORTEN     7

// Reset values
`define ASTX_RST_STATCTL   8'h02
`define ASTX_RST_BAUD      8'h00
`define ASTX_RST_TXBUF     8'h00

// Timing: one instruction cycle in oscillator clocks, and the
// baud generator output runs at this multiple of the bit rate
`define ASTX_TCY_CLKS      3'h4
`define ASTX_OVERSAMPLE    7'h40

// Frame lengths in bits including start and stop
`define ASTX_FRAME8        4'ha
`define ASTX_FRAME9        4'hb

`endif

// File: hdl/astx_top.v
/*
 * Asynchronous serial transmitter: register file on a plain
 * address/strobe port, an 8-bit baud divisor with a x64 output,
 * a transmit buffer feeding a hidden shift register, the
 * buffer-empty flag with its request, and the transmit pin.
 * Assumes one 250 MHz clock standing in for the oscillator,
 * synchronous inputs, and a pad that resolves tx_out/tx_oe.
 */
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
`include "astx_consts.vh"

// Operation
// - Frame is start bit, eight or nine data bits, one stop bit
// - One dedicated 8-bit baud divisor derives bit timing from clock
// - Divisor output clock runs at sixty-four times the bit rate
// - Transmit runs independently, sharing format and rate with receive
// - No hardware parity; software may place parity in ninth bit
// - All serial activity halts while sleep is asserted
// - Asynchronous mode whenever clocked-mode select bit 4 is zero
// - Shifter reloads only after stop bit, then at once if buffered
// - Buffer move takes one instruction cycle, then sets empty flag
// - Empty flag ignores software clear; clears only on buffer write
// - Buffer-empty request raised only when its enable is set
// - Read-only shifter-empty status bit, no request logic attached
// - Shift register is never visible at any register address
// - Transmit enable permits sending; shifting needs data and tick
// - Buffer accepted before or after enable; empty shifter takes it
// - Clearing enable mid-frame aborts and releases the pin
// - Ninth bit written before data byte is the one sent
// - Clearing port or transmit enable resets transmitter to idle
// - Writing the divisor clears the baud counter immediately
module astx_top (
    input  wire       clk_sys,
    input  wire       rst_n,
    input  wire [2:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    input  wire       sleep_req,
    output reg        tx_out,
    output reg        tx_oe,
    output reg        irq_req
);

    // Transmitter states
    localparam ST_IDLE  = 2'h0;
    localparam ST_LOAD  = 2'h1;
    localparam ST_WAIT  = 2'h2;
    localparam ST_SHIFT = 2'h3;

    // Software-visible storage
    reg [7:0]  statctl_ff;
    reg [7:0]  nxt_statctl;
    reg [7:0]  txbuf_ff;
    reg [7:0]  nxt_txbuf;
    reg        buf_full_ff;
    reg        nxt_buf_full;
    reg        empty_flag_ff;
    reg        nxt_empty_flag;
    reg [7:0]  baud_div_ff;
    reg [7:0]  nxt_baud_div;
    reg        empty_ie_ff;
    reg        nxt_empty_ie;
    reg        port_en_ff;
    reg        nxt_port_en;

    // Timing and shifter state
    reg [7:0]  baud_cnt_ff;
    reg [7:0]  nxt_baud_cnt;
    reg [5:0]  sub_cnt_ff;
    reg [5:0]  nxt_sub_cnt;
    reg [1:0]  state_ff;
    reg [1:0]  nxt_state;
    reg [2:0]  tcy_cnt_ff;
    reg [2:0]  nxt_tcy_cnt;
    reg [10:0] shifter_ff;
    reg [10:0] nxt_shifter;
    reg [3:0]  bits_left_ff;
    reg [3:0]  nxt_bits_left;
    reg        sh_empty_ff;
    reg        nxt_sh_empty;

    // Output flops
    reg [7:0]  nxt_rdata;
    reg        nxt_tx_out;
    reg        nxt_tx_oe;
    reg        nxt_irq;

    // Decoded strobes and qualifiers
    wire       wr_sc;
    wire       wr_buf;
    wire       wr_baud;
    wire       wr_ie;
    wire       wr_pc;
    wire       run;
    wire       active;
    wire       baud_tick;
    wire       bit_tick;
    wire       nine_sel;
    wire [3:0] frame_len;
    wire [7:0] statctl_rd;

    assign wr_sc   = reg_wr && (reg_addr == `ASTX_OFS_STATCTL);
    assign wr_buf  = reg_wr && (reg_addr == `ASTX_OFS_TXBUF);
    assign wr_baud = reg_wr && (reg_addr == `ASTX_OFS_BAUD);
    assign wr_ie   = reg_wr && (reg_addr == `ASTX_OFS_ENABLES);
    assign wr_pc   = reg_wr && (reg_addr == `ASTX_OFS_PORTCTL);

    // Transmitter runs only in async mode with both enables set
    assign active = port_en_ff && statctl_ff[`ASTX_SC_TRANSMIT_ENABLE]
                    && !statctl_ff[`ASTX_SC_CLKMODE];
    // Sleep freezes every counter and the shifter in place
    assign run    = active && !sleep_req;

    // Divisor counter wraps after divisor+1 clocks: the x64 clock
    assign baud_tick = run && (baud_cnt_ff == baud_div_ff);
    // Every 64th x64 tick is one bit time
    assign bit_tick  = baud_tick && (sub_cnt_ff == 6'h3f);

    assign nine_sel  = statctl_ff[`ASTX_SC_NINE];
    // Format and rate are shared settings; no receive logic lives here
    assign frame_len = nine_sel ? `ASTX_FRAME9 : `ASTX_FRAME8;

    // Status view: live shifter-empty bit, bits 3:2 read zero
    assign statctl_rd = {statctl_ff[7:4], 2'b00, sh_empty_ff,
                         statctl_ff[`ASTX_SC_NINTH]};

    // Control register writes; shifter-empty is not writable
    always @* begin
        nxt_statctl  = statctl_ff;
        nxt_baud_div = baud_div_ff;
        nxt_empty_ie = empty_ie_ff;
        nxt_port_en  = port_en_ff;
        if (wr_sc) begin
            nxt_statctl = reg_wdata & 8'hf1;
        end
        if (wr_baud) begin
            nxt_baud_div = reg_wdata;
        end
        if (wr_ie) begin
            nxt_empty_ie = reg_wdata[`ASTX_EN_BUFEMPTY];
        end
        if (wr_pc) begin
            nxt_port_en = reg_wdata[`ASTX_PC_PORTEN];
        end
    end

    // Baud divisor and x64 sub-counter
    always @* begin
        nxt_baud_cnt = baud_cnt_ff;
        nxt_sub_cnt  = sub_cnt_ff;
        if (wr_baud || !active) begin
            // New rate applies without waiting for a wrap
            nxt_baud_cnt = 8'h00;
            nxt_sub_cnt  = 6'h00;
        end else if (run) begin
            if (baud_tick) begin
                nxt_baud_cnt = 8'h00;
                nxt_sub_cnt  = sub_cnt_ff + 6'h01;
            end else begin
                nxt_baud_cnt = baud_cnt_ff + 8'h01;
            end
        end
    end

    // Buffer, empty flag and transmitter state machine
    always @* begin
        nxt_txbuf      = txbuf_ff;
        nxt_buf_full   = buf_full_ff;
        nxt_empty_flag = empty_flag_ff;
        nxt_state      = state_ff;
        nxt_tcy_cnt    = tcy_cnt_ff;
        nxt_shifter    = shifter_ff;
        nxt_bits_left  = bits_left_ff;
        nxt_sh_empty   = sh_empty_ff;

        // Buffer accepts data whether or not sending is enabled
        if (wr_buf) begin
            nxt_txbuf      = reg_wdata;
            nxt_buf_full   = 1'b1;
            nxt_empty_flag = 1'b0;
        end

        if (!active) begin
            // Abort: frame dropped, shifter empty, buffer kept
            nxt_state     = ST_IDLE;
            nxt_sh_empty  = 1'b1;
            nxt_bits_left = 4'h0;
            nxt_tcy_cnt   = 3'h0;
        end else if (run) begin
            case (state_ff)
                ST_IDLE: begin
                    // Empty shifter takes buffered data straight away
                    if (buf_full_ff) begin
                        nxt_state   = ST_LOAD;
                        nxt_tcy_cnt = 3'h1;
                    end
                end
                ST_LOAD: begin
                    if (tcy_cnt_ff == `ASTX_TCY_CLKS) begin
                        // Move after one instruction cycle; the ninth
                        // bit is taken now, so it must precede the byte.
                        // Ninth bit is sent as stored, no parity made
                        nxt_shifter = {1'b1,
                                       nine_sel ? statctl_ff[`ASTX_SC_NINTH]
                                                : 1'b1,
                                       txbuf_ff, 1'b0};
                        nxt_sh_empty  = 1'b0;
                        nxt_bits_left = frame_len;
                        nxt_state     = ST_WAIT;
                        // A write landing now is new data and stays put
                        if (!wr_buf) begin
                            nxt_buf_full   = 1'b0;
                            nxt_empty_flag = 1'b1;
                        end
                    end else begin
                        nxt_tcy_cnt = tcy_cnt_ff + 3'h1;
                    end
                end
                ST_WAIT: begin
                    // First bit time starts on a shift clock
                    if (bit_tick) begin
                        nxt_state = ST_SHIFT;
                    end
                end
                default: begin
                    if (bit_tick) begin
                        // Shift out LSB first, idle ones fill in
                        nxt_shifter   = {1'b1, shifter_ff[10:1]};
                        nxt_bits_left = bits_left_ff - 4'h1;
                        if (bits_left_ff == 4'h1) begin
                            // Stop bit done; reload at once if buffered
                            nxt_sh_empty = 1'b1;
                            if (buf_full_ff) begin
                                nxt_state   = ST_LOAD;
                                nxt_tcy_cnt = 3'h1;
                            end else begin
                                nxt_state = ST_IDLE;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // Pin, request and read data
    always @* begin
        nxt_tx_oe  = active;
        nxt_tx_out = 1'b1;
        if (state_ff == ST_SHIFT) begin
            // Frame bits come only from the hidden shifter
            nxt_tx_out = shifter_ff[0];
        end
        nxt_irq = empty_flag_ff && empty_ie_ff;
        // Read has no side effect; unmapped offsets read zero
        nxt_rdata = 8'h00;
        if (reg_rd) begin
            if (reg_addr == `ASTX_OFS_STATCTL) begin
                nxt_rdata = statctl_rd;
            end else if (reg_addr == `ASTX_OFS_TXBUF) begin
                nxt_rdata = txbuf_ff;
            end else if (reg_addr == `ASTX_OFS_BAUD) begin
                nxt_rdata = baud_div_ff;
            end else if (reg_addr == `ASTX_OFS_FLAGS) begin
                nxt_rdata = {6'h00, empty_flag_ff, 1'b0};
            end else if (reg_addr == `ASTX_OFS_ENABLES) begin
                nxt_rdata = {6'h00, empty_ie_ff, 1'b0};
            end else if (reg_addr == `ASTX_OFS_PORTCTL) begin
                nxt_rdata = {port_en_ff, 7'h00};
            end
        end
    end

    // All state flops
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            statctl_ff    <= `ASTX_RST_STATCTL;
            txbuf_ff      <= `ASTX_RST_TXBUF;
            buf_full_ff   <= 1'b0;
            empty_flag_ff <= 1'b1;
            baud_div_ff   <= `ASTX_RST_BAUD;
            empty_ie_ff   <= 1'b0;
            port_en_ff    <= 1'b0;
            baud_cnt_ff   <= 8'h00;
            sub_cnt_ff    <= 6'h00;
            state_ff      <= ST_IDLE;
            tcy_cnt_ff    <= 3'h0;
            shifter_ff    <= 11'h7ff;
            bits_left_ff  <= 4'h0;
            sh_empty_ff   <= 1'b1;
            reg_rdata     <= 8'h00;
            tx_out        <= 1'b1;
            tx_oe         <= 1'b0;
            irq_req       <= 1'b0;
        end else begin
            statctl_ff    <= nxt_statctl;
            txbuf_ff      <= nxt_txbuf;
            buf_full_ff   <= nxt_buf_full;
            empty_flag_ff <= nxt_empty_flag;
            baud_div_ff   <= nxt_baud_div;
            empty_ie_ff   <= nxt_empty_ie;
            port_en_ff    <= nxt_port_en;
            baud_cnt_ff   <= nxt_baud_cnt;
            sub_cnt_ff    <= nxt_sub_cnt;
            state_ff      <= nxt_state;
            tcy_cnt_ff    <= nxt_tcy_cnt;
            shifter_ff    <= nxt_shifter;
            bits_left_ff  <= nxt_bits_left;
            sh_empty_ff   <= nxt_sh_empty;
            reg_rdata     <= nxt_rdata;
            tx_out        <= nxt_tx_out;
            tx_oe         <= nxt_tx_oe;
            irq_req       <= nxt_irq;
        end
    end

endmodule

// File: verification/astx_assertions.sv
/* Port-level checker for astx_top, bound from the bench top file.
   Assumes one clock domain and an active-low reset. */
`timescale 1ns/1ns
module astx_assertions (
    input wire       clk_sys,
    input wire       rst_n,
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       sleep_req,
    input wire       tx_out,
    input wire       tx_oe,
    input wire       irq_req
);
    reg [15:0] low_cnt_ff;
    reg        irq_en_ff;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Low run on the driven pin; shadow of the request enable
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt_ff <= 16'h0000;
            irq_en_ff  <= 1'b0;
        end else begin
            low_cnt_ff <= (tx_oe && !tx_out) ? low_cnt_ff + 16'h0001 : 16'h0000;
            if (reg_wr && reg_addr == 3'h4)
                irq_en_ff <= reg_wdata[1];
        end
    end
    a_unmapped_zero: assert property (reg_rd && reg_addr[2:1] == 2'b11 |=>
        reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_divisor_readback: assert property (reg_wr && reg_addr == 3'h2 ##2
        reg_rd && reg_addr == 3'h2 |=> reg_rdata == $past(reg_wdata, 3))
        else $error("divisor read back differs");
    a_flag_write_clear: assert property (reg_wr && reg_addr == 3'h1 ##2
        reg_rd && reg_addr == 3'h3 |=> !reg_rdata[1]) else $error("empty flag kept");
    a_irq_gated: assert property (irq_req |-> $past(irq_en_ff))
        else $error("request without enable");
    a_disable_release: assert property (reg_wr && (reg_addr == 3'h0 &&
        !reg_wdata[5] || reg_addr == 3'h5 && !reg_wdata[7]) |-> ##[1:3] !tx_oe)
        else $error("pin still driven after disable");
    a_bit_multiple: assert property ($rose(tx_out) && tx_oe && $past(tx_oe) |->
        low_cnt_ff[5:0] == 6'h00 && low_cnt_ff != 16'h0000) else $error("bit time off");
    a_sleep_hold: assert property (sleep_req && $past(sleep_req) &&
        $past(sleep_req, 2) |-> $stable(tx_out)) else $error("pin moved in sleep");
    a_drive_high: assert property ($rose(tx_oe) |-> tx_out)
        else $error("pin not idle high");
endmodule

// File: verification/astx_rx_model.sv
/* Remote receiver listening on the resolved transmit line.
   Assumes a pulled-up line and a bit time set by the bench. */
`timescale 1ns/1ns
module astx_rx_model (
    input  wire        clk_sys,
    input  wire        line,
    input  wire [15:0] bit_clks,
    input  wire        nine,
    output reg  [8:0]  word,
    output reg         stop_ok,
    output reg  [7:0]  frames
);
    integer i;
    // Mid-bit sampling; a glitch shorter than half a bit is dropped
    initial begin
        word    = 9'h000;
        stop_ok = 1'b0;
        frames  = 8'h00;
        forever begin
            @(negedge line);
            repeat (bit_clks / 2) @(posedge clk_sys);
            if (line === 1'b0) begin
                word = 9'h000;
                for (i = 0; i < (nine ? 9 : 8); i = i + 1) begin
                    repeat (bit_clks) @(posedge clk_sys);
                    word[i] = line;
                end
                repeat (bit_clks) @(posedge clk_sys);
                stop_ok = line;
                frames  = frames + 8'h01;
            end
        end
    end
endmodule

// File: verification/astx_top_test.sv
/* Self-checking bench for astx_top: registers, frames, requests,
   blocking and aborts. Assumes a pull-up on the transmit pin. */
`timescale 1ns/1ns
module astx_top_test;
    reg         clk_sys;
    reg         rst_n;
    reg  [2:0]  reg_addr;
    reg  [7:0]  reg_wdata;
    reg         reg_wr;
    reg         reg_rd;
    reg         sleep_req;
    reg         nine;
    reg  [15:0] bit_clks;
    reg  [7:0]  v;
    wire [7:0]  reg_rdata;
    wire        tx_out;
    wire        tx_oe;
    wire        irq_req;
    wire        line;
    wire [8:0]  rx_word;
    wire        rx_stop;
    wire [7:0]  rx_frames;
    integer     err_total;
    integer     checked;
    integer     cycles;
    integer     k;
    assign line = tx_oe ? tx_out : 1'b1;
    astx_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sleep_req(sleep_req), .tx_out(tx_out), .tx_oe(tx_oe), .irq_req(irq_req));
    astx_rx_model u_rx (.clk_sys(clk_sys), .line(line), .bit_clks(bit_clks), .nine(nine),
        .word(rx_word), .stop_ok(rx_stop), .frames(rx_frames));
    task end_of_test;
        if (err_total == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk8(input [7:0] got, input [7:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            err_total = err_total + 1;
        end
    endtask
    task chk_val(input [15:0] got, input [15:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            err_total = err_total + 1;
        end
    endtask
    // Gap cycle after each strobe keeps one assignment per time step
    task wr(input [2:0] a, input [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        @(posedge clk_sys);
    endtask
    task rd(input [2:0] a, output [7:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clk_sys);
    endtask
    task wait_low;
        k = 0;
        while (line !== 1'b0 && k < 20000) begin
            @(negedge clk_sys);
            k = k + 1;
        end
    endtask
    task wait_frame(input [7:0] n, input [8:0] exp);
        k = 0;
        while (rx_frames !== n && k < 8000) begin
            @(posedge clk_sys);
            k = k + 1;
        end
        chk_val({6'h00, rx_stop, rx_word}, {7'h01, exp});
    endtask
    task t_regs;
        integer i;
        wr(3'h6, 8'hff);
        for (i = 0; i < 8; i = i + 1) begin
            rd(i[2:0], v);
            chk8(v, (i == 0 || i == 3) ? 8'h02 : 8'h00);
        end
        wr(3'h2, 8'h5a);
        rd(3'h2, v);
        chk8(v, 8'h5a);
    endtask
    task t_frame(input [7:0] div, input n9, input b9, input [7:0] d0, input [7:0] d1);
        reg [7:0] n;
        bit_clks = 16'h0040 * ({8'h00, div} + 16'h0001);
        nine = n9;
        n = rx_frames;
        wr(3'h0, 8'h00);
        wr(3'h2, div);
        wr(3'h5, 8'h80);
        wr(3'h4, 8'h02);
        wr(3'h0, {1'b0, n9, 5'h00, b9});
        wr(3'h1, d0);
        rd(3'h3, v);
        chk8(v, 8'h00);
        wr(3'h0, {1'b0, n9, 5'h10, b9});
        // Host waits for the buffer to drain into the shifter first
        k = 0;
        while (v[1] !== 1'b1 && k < 100) begin
            rd(3'h3, v);
            k = k + 1;
        end
        chk8(v, 8'h02);
        wr(3'h1, d1);
        wait_low;
        k = 0;
        while (line === 1'b0 && k < 20000) begin
            @(negedge clk_sys);
            k = k + 1;
        end
        chk_val(k[15:0], bit_clks);
        wait_frame(n + 8'h01, {n9 & b9, d0});
        wait_frame(n + 8'h02, {n9 & b9, d1});
        repeat (bit_clks) @(posedge clk_sys);
        rd(3'h0, v);
        chk8(v, {1'b0, n9, 5'h11, b9});
        rd(3'h3, v);
        chk8(v, 8'h02);
        chk8({7'h00, irq_req}, 8'h01);
        wr(3'h4, 8'h00);
        wr(3'h3, 8'h00);
        chk8({7'h00, irq_req}, 8'h00);
        rd(3'h3, v);
        chk8(v, 8'h02);
    endtask
    task t_block(input slp, input [7:0] sc);
        reg [7:0] n;
        bit_clks = 16'h0040;
        nine = 1'b0;
        n = rx_frames;
        sleep_req <= slp;
        wr(3'h0, 8'h00);
        wr(3'h2, 8'h00);
        wr(3'h5, 8'h80);
        wr(3'h0, sc);
        wr(3'h1, 8'h55);
        k = 0;
        repeat (800) begin
            @(negedge clk_sys);
            k = (line !== 1'b1) ? k + 1 : k;
        end
        chk_val(k[15:0], 16'h0000);
        @(posedge clk_sys);
        sleep_req <= 1'b0;
        if (slp)
            wait_frame(n + 8'h01, 9'h055);
        wr(3'h0, 8'h00);
    endtask
    task t_abort(input [2:0] a, input [7:0] exp);
        bit_clks = 16'h0100;
        wr(3'h2, 8'h03);
        wr(3'h5, 8'h80);
        wr(3'h0, 8'h20);
        wr(3'h1, 8'h00);
        wait_low;
        repeat (600) @(posedge clk_sys);
        wr(a, 8'h00);
        repeat (2) @(posedge clk_sys);
        chk8({7'h00, tx_oe}, 8'h00);
        rd(3'h0, v);
        chk8(v & 8'h22, exp);
        repeat (3000) @(posedge clk_sys);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Ceiling well above the longest run of frames and aborts
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 60000) begin
            err_total = err_total + 1;
            end_of_test;
        end
    end
    initial begin
        {rst_n, reg_wr, reg_rd, sleep_req, nine} = 5'h00;
        {reg_addr, reg_wdata, v} = 19'h00000;
        bit_clks = 16'h0040;
        err_total = 0;
        checked = 0;
        cycles = 0;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_regs;
        t_frame(8'h00, 1'b0, 1'b0, 8'ha5, 8'h3c);
        t_frame(8'h01, 1'b1, 1'b1, 8'h81, 8'h7e);
        t_block(1'b1, 8'h20);
        t_block(1'b0, 8'h30);
        t_abort(3'h0, 8'h02);
        t_abort(3'h5, 8'h22);
        end_of_test;
    end
endmodule
bind astx_top astx_assertions u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sleep_req(sleep_req), .tx_out(tx_out), .tx_oe(tx_oe),
    .irq_req(irq_req));
